/* bench/hbr_dev_model.sv */
// Behavioural model of the full-bridge gate driver as the host sees it
`timescale 1ns/1ps
module hbr_dev_model #(
  parameter int SC_FILT = 450,  // Short filter, 9 us at 50 MHz
  parameter int DIAG_LO = 155,  // Shortest pulse that clears diagnosis
  parameter int OFF_MIN = 350   // Disable held past 7 us shuts down
) (
  input  wire logic mclk,
  input  wire logic por_n,
  input  wire logic pwm_in,
  input  wire logic dir_in,
  input  wire logic deadtime_disable_input,
  input  wire logic awake_in,
  input  wire logic ot_inj,
  input  wire logic uv_inj,
  input  wire logic sc_inj,
  output logic      high_gate_one,
  output logic      low_gate_one,
  output logic      high_gate_two,
  output logic      low_gate_two,
  output logic      shutdown_fault_flag,
  output logic      fault_reason_flag
);
  int   dis_cnt;   // Cycles the disable pin has stayed high
  int   sc_cnt;    // Unbroken cycles of short condition
  logic sc_latch;  // Half-bridge one latched off
  logic run;       // Enabled, awake, not shut down
  logic rst_n;     // Power-on or sleep wipes all state
  logic pwm_eff;   // Duty pin, open reads low
  logic dir_eff;   // Direction pin, open reads low
  logic dis_eff;   // Disable pin, open reads high
  // Internal pulls: an open duty pin brakes, an open direction pin reads low, an open disable disables
  assign pwm_eff = (pwm_in === 1'b1);
  assign dir_eff = (dir_in === 1'b1);
  assign dis_eff = (deadtime_disable_input !== 1'b0);
  assign rst_n = por_n & awake_in;
  // Pulse timing and short latch; short episodes never add up
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dis_cnt  <= 0;
      sc_cnt   <= 0;
      sc_latch <= 1'b0;
    end else begin
      dis_cnt <= dis_eff ? dis_cnt + 1 : 0;
      sc_cnt  <= sc_inj ? sc_cnt + 1 : 0;
      // Falling disable after a long enough pulse clears diagnosis
      if (!dis_eff && dis_cnt >= DIAG_LO) begin
        sc_latch <= 1'b0;
      end else if (sc_cnt >= SC_FILT) begin
        sc_latch <= 1'b1;
      end
    end
  end
  // Running while disable is low or only briefly high
  assign run = rst_n && dis_cnt <= OFF_MIN;
  // Decode; undervoltage hits gate one high only, a short its half-bridge
  assign high_gate_one = run && !uv_inj && !sc_latch && (!pwm_eff || !dir_eff);
  assign low_gate_one  = run && !sc_latch && pwm_eff && dir_eff;
  assign high_gate_two = run && (!pwm_eff || dir_eff);
  assign low_gate_two  = run && pwm_eff && !dir_eff;
  // Open-drain flags released whenever nothing is wrong or shut down
  assign shutdown_fault_flag = !(run && (uv_inj || sc_latch));
  assign fault_reason_flag   = !(run && (uv_inj || (ot_inj && !sc_latch)));
endmodule

/* bench/testbench.sv */
// Self-checking bench for the bridge driver host controller
`timescale 1ns/1ps
module testbench;
  localparam int CHG = 400;  // Short charge wait, still above 351
  localparam int HSM = 200;  // Short high-side on limit
  localparam int PER = 100;  // Short PWM period
  logic        mclk;
  logic        arst_n;
  logic        enable;
  logic        sleep_req;
  logic        clear_req;
  logic        fast_decay;
  logic        dir_req;
  logic [11:0] duty;
  logic        ot_inj;      // Injected overheat
  logic        uv_inj;      // Injected undervoltage
  logic        sc_inj;      // Injected short condition
  logic        pwm_out;
  logic        dir_out;
  logic        deadtime_disable_input;
  logic        awake_out;
  logic        ready;
  logic [1:0]  fault_code;
  logic        shutdown_fault_flag;
  logic        fault_reason_flag;
  logic [3:0]  gates;       // High one, low one, high two, low two
  logic [3:0]  probe;       // Pins counted by meas
  int          err_total;
  int          tests_run;
  int          hi;
  assign probe = {gates[0], deadtime_disable_input, dir_out, pwm_out};
  hbr_host #(.CHARGE_CYC(CHG), .HS_MAX_CYC(HSM), .PERIOD(PER)) hbr_host_inst (
    .mclk(mclk), .arst_n(arst_n), .enable(enable), .sleep_req(sleep_req),
    .clear_req(clear_req), .fast_decay(fast_decay), .dir_req(dir_req), .duty(duty),
    .shutdown_fault_flag(shutdown_fault_flag), .fault_reason_flag(fault_reason_flag),
    .pwm_out(pwm_out), .dir_out(dir_out), .deadtime_disable_input(deadtime_disable_input),
    .awake_out(awake_out), .ready(ready), .fault_code(fault_code));
  hbr_dev_model hbr_dev_model_inst (
    .mclk(mclk), .por_n(arst_n), .pwm_in(pwm_out), .dir_in(dir_out),
    .deadtime_disable_input(deadtime_disable_input), .awake_in(awake_out),
    .ot_inj(ot_inj), .uv_inj(uv_inj), .sc_inj(sc_inj), .high_gate_one(gates[3]),
    .low_gate_one(gates[2]), .high_gate_two(gates[1]), .low_gate_two(gates[0]),
    .shutdown_fault_flag(shutdown_fault_flag), .fault_reason_flag(fault_reason_flag));
  // Free-running 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // One comparison, four-state exact
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Count high cycles of one probed pin, starting with the value standing now
  task automatic meas(input int sel, input int n, output int cnt);
    cnt = 0;
    repeat (n) begin
      cnt += int'(probe[sel]);
      @(negedge mclk);
    end
  endtask
  // Bounded wait for the charge wait to end
  task automatic wait_ready();
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 1000) begin
      @(negedge mclk);
      n++;
    end
    chk("charge_wait", n >= CHG - 1, 1'b1);
    chk("ready", ready, 1'b1);
  endtask
  task automatic t_boot();
    cyc(8);
    chk("reset_pins", {deadtime_disable_input, awake_out, ready}, 3'h6);
    arst_n = 1'b1;
    wait_ready();
    chk("run_disable", deadtime_disable_input, 1'b0);
    $display("test boot done");
  endtask
  task automatic t_decode();
    for (int k = 0; k < 4; k++) begin
      duty = k[1] ? 12'(PER) : 12'h000;
      dir_req = k[0];
      cyc(4);
      chk("gates", gates, k[1] ? 4'hA : (k[0] ? 4'h6 : 4'h9));
    end
    $display("test decode done");
  endtask
  task automatic t_duty();
    dir_req = 1'b0;
    duty = 12'h01E;
    cyc(PER);
    meas(0, PER, hi);
    chk("pwm_high", hi, PER - 30);
    meas(3, PER, hi);
    chk("low_gate_share", hi, PER - 30);
    duty = 12'(PER);
    cyc(PER);
    meas(0, 2 * (HSM - 1 + hbr_pkg::REFRESH_CYC), hi);
    chk("refresh", hi, 2 * hbr_pkg::REFRESH_CYC);
    fast_decay = 1'b1;
    duty = 12'h01E;
    for (int d = 0; d < 2; d++) begin
      dir_req = d[0];
      cyc(4);
      meas(0, PER, hi);
      chk("fd_pwm", hi, PER);
      meas(1, PER, hi);
      chk("fd_dir", hi, d ? 30 : PER - 30);
    end
    fast_decay = 1'b0;
    dir_req = 1'b0;
    duty = 12'h000;
    cyc(4);
    $display("test duty done");
  endtask
  // Overheat only warns; undervoltage drops one gate and recovers
  task automatic t_flags();
    for (int k = 1; k < 3; k++) begin
      {uv_inj, ot_inj} = k[1:0];
      cyc(4);
      chk("code", fault_code, k == 1 ? hbr_pkg::FLT_HOT : hbr_pkg::FLT_LOWV);
      chk("gates", gates, k == 1 ? 4'h9 : 4'h1);
    end
    {uv_inj, ot_inj} = 2'b00;
    cyc(4);
    chk("restart", {gates, fault_code}, 6'h24);
    $display("test flags done");
  endtask
  task automatic t_short();
    for (int k = 0; k < 2; k++) begin
      sc_inj = 1'b1;
      cyc(300);
      sc_inj = 1'b0;
      cyc(1);
    end
    cyc(4);
    chk("short_filter", fault_code, hbr_pkg::FLT_NONE);
    sc_inj = 1'b1;
    cyc(460);
    sc_inj = 1'b0;
    cyc(20);
    chk("short_latch", {gates, fault_code}, {4'h1, hbr_pkg::FLT_SHORT});
    clear_req = 1'b1;
    cyc(1);
    clear_req = 1'b0;
    meas(2, 300, hi);
    chk("clear_pulse", hi, hbr_pkg::DIAG_CYC);
    chk("cleared", {gates, fault_code, ready}, {4'h9, hbr_pkg::FLT_NONE, 1'b1});
    $display("test short done");
  endtask
  // Long disable: all gates off, flags released despite a fault
  task automatic t_off();
    enable = 1'b0;
    cyc(360);
    uv_inj = 1'b1;
    cyc(4);
    chk("off", {gates, fault_code}, 6'h00);
    uv_inj = 1'b0;
    enable = 1'b1;
    wait_ready();
    $display("test off done");
  endtask
  task automatic t_sleep();
    sc_inj = 1'b1;
    cyc(460);
    sc_inj = 1'b0;
    cyc(4);
    chk("short_again", fault_code, hbr_pkg::FLT_SHORT);
    sleep_req = 1'b1;
    cyc(2);
    chk("sleep", {awake_out, pwm_out, dir_out, deadtime_disable_input}, 4'h1);
    sleep_req = 1'b0;
    wait_ready();
    chk("wake_reinit", fault_code, hbr_pkg::FLT_NONE);
    $display("test sleep done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Main sequence, inputs move at the falling edge
  initial begin
    err_total = 0;
    tests_run = 0;
    arst_n = 1'b0;
    enable = 1'b1;
    sleep_req = 1'b0;
    clear_req = 1'b0;
    fast_decay = 1'b0;
    dir_req = 1'b0;
    duty = 12'h000;
    ot_inj = 1'b0;
    uv_inj = 1'b0;
    sc_inj = 1'b0;
    t_boot();
    t_decode();
    t_duty();
    t_flags();
    t_short();
    t_off();
    t_sleep();
    complete_run();
  end
  // Watchdog, well past the roughly 4800 cycles the tests need
  initial begin
    repeat (30000) @(posedge mclk);
    err_total++;
    complete_run();
  end
endmodule

/* common/hbr_pkg.sv */
// Constants shared by the bridge driver host controller and its PWM generator
package hbr_pkg;
  // Clock and period of mclk
  localparam int CLK_HZ        = 50_000_000;
  localparam int CLK_PER_NS    = 1_000_000_000 / CLK_HZ;
  // Diagnosis clear window on the dead-time/disable pin, ns
  localparam int DIAG_MIN_NS   = 3100;
  localparam int DIAG_MAX_NS   = 3600;
  // Least time rounds up, longest rounds down
  localparam int DIAG_MIN_CYC  = (DIAG_MIN_NS + CLK_PER_NS - 1) / CLK_PER_NS;
  localparam int DIAG_MAX_CYC  = DIAG_MAX_NS / CLK_PER_NS;
  // Aim at the middle of the window for margin on both sides
  localparam int DIAG_CYC      = (DIAG_MIN_CYC + DIAG_MAX_CYC) / 2;
  // Disable held longer than this shuts the output stages down, ns
  localparam int OFF_NS        = 7000;
  localparam int OFF_CYC       = OFF_NS / CLK_PER_NS + 1;
  // Bootstrap refresh pulse after a long high-side on time, ns
  localparam int REFRESH_NS    = 1000;
  localparam int REFRESH_CYC   = REFRESH_NS / CLK_PER_NS;
  // Longest high-side on time before a refresh, us
  localparam int HS_MAX_US     = 1000;
  localparam int HS_MAX_CYC    = HS_MAX_US * 1000 / CLK_PER_NS;
  // Bootstrap charge wait at start-up, us
  localparam int CHARGE_US     = 1000;
  localparam int CHARGE_CYC    = CHARGE_US * 1000 / CLK_PER_NS;
  // PWM rate and highest duty in high-side switching
  localparam int PWM_HZ        = 20_000;
  localparam int PERIOD_CYC    = CLK_HZ / PWM_HZ;
  localparam int DUTY_MAX_PCT  = 96;
  localparam int DUTY_MAX_CYC  = PERIOD_CYC * DUTY_MAX_PCT / 100;
  // Fault codes reported to the user
  localparam logic [1:0] FLT_NONE  = 2'h0;
  localparam logic [1:0] FLT_HOT   = 2'h1;
  localparam logic [1:0] FLT_SHORT = 2'h2;
  localparam logic [1:0] FLT_LOWV  = 2'h3;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_SLEEP,
    ST_CHARGE,
    ST_RUN,
    ST_CLEAR,
    ST_OFF
  } hbr_state_t;
endpackage

/* common/hbr_pwm_if.sv */
// Carrier between the host sequencer and its PWM pattern generator
`timescale 1ns/1ps
interface hbr_pwm_if #(
  parameter int W = 12
);
  logic         run;       // Generator counting
  logic [W-1:0] high_cyc;  // Cycles per period with pattern high
  logic         pattern;   // Registered raw pattern
  modport gen (input run, input high_cyc, output pattern);
  modport ctl (output run, output high_cyc, input pattern);
endinterface

/* hw/hbr_host.sv */
// Host controller driving a full-bridge gate driver through its pins
// What this block does
// - Disable pulse 3.1-3.6us clears diagnosis
// - Disable over 7us shuts all gates down
// - Refresh pulse after 1ms high-side on time
// - Leave bootstrap charge time, duty max 96% at the default 20 kHz period
// - Start disabled, charge, enable, then patterns
// - Fast decay: duty high, pattern on direction
`timescale 1ns/1ps
module hbr_host #(
  parameter int CHARGE_CYC = hbr_pkg::CHARGE_CYC,  // Bootstrap charge wait
  parameter int HS_MAX_CYC = hbr_pkg::HS_MAX_CYC,  // Longest high-side on run
  parameter int PERIOD     = hbr_pkg::PERIOD_CYC   // PWM period in cycles
) (
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       enable,
  input  wire logic       sleep_req,
  input  wire logic       clear_req,
  input  wire logic       fast_decay,
  input  wire logic       dir_req,
  input  wire logic [11:0] duty,
  input  wire logic       shutdown_fault_flag,
  input  wire logic       fault_reason_flag,
  output logic            pwm_out,
  output logic            dir_out,
  output logic            deadtime_disable_input,
  output logic            awake_out,
  output logic            ready,
  output logic [1:0]      fault_code
);
  localparam int TW = $clog2(CHARGE_CYC + 2);
  localparam int HW = $clog2(HS_MAX_CYC + 2);
  localparam int RW = $clog2(hbr_pkg::REFRESH_CYC + 1);
  // Duty ceiling; never above one period, so the pin high time cannot wrap
  localparam int DLIM = (hbr_pkg::DUTY_MAX_CYC < PERIOD) ? hbr_pkg::DUTY_MAX_CYC : PERIOD;

  // Refuse counts the sequence cannot serve
  if (CHARGE_CYC <= hbr_pkg::OFF_CYC || HS_MAX_CYC < 2 || PERIOD > 4096
      || TW < $clog2(hbr_pkg::OFF_CYC + 2)) begin : g_chk
    $error("Charge wait must exceed the shutdown window");
  end

  // Flag pair to fault code
  function automatic logic [1:0] flt_decode(input logic f1, input logic f2);
    unique case ({f1, f2})
      2'b11:   flt_decode = hbr_pkg::FLT_NONE;
      2'b10:   flt_decode = hbr_pkg::FLT_HOT;
      2'b01:   flt_decode = hbr_pkg::FLT_SHORT;
      default: flt_decode = hbr_pkg::FLT_LOWV;
    endcase
  endfunction

  hbr_pkg::hbr_state_t state, next_state;   // Sequencer
  logic [TW-1:0] tmr, next_tmr;             // Time in current state
  logic [HW-1:0] hs_len, next_hs_len;       // Consecutive duty-low cycles
  logic [RW-1:0] refr, next_refr;           // Refresh pulse remaining
  logic          next_pwm, next_dir, next_dis, next_awake, next_ready;
  logic [1:0]    next_fault;
  logic          active;                    // Patterns may be applied
  logic          start_refr;                // Refresh begins this cycle
  logic [11:0]   duty_lim;                  // Duty after the clamp

  hbr_pwm_if #(.W(12)) pif ();

  hbr_pwm_gen #(.PERIOD(PERIOD), .W(12)) u_gen (
    .mclk   (mclk),
    .arst_n (arst_n),
    .pif    (pif)
  );

  // Generator feed: pin high time is the low-gate share of the period
  always_comb begin
    duty_lim     = (duty > 12'(DLIM)) ? 12'(DLIM)
                                      : duty;
    pif.high_cyc = 12'(PERIOD) - duty_lim;
    pif.run      = active;
  end

  // Sequencer next state
  always_comb begin
    next_state = state;
    next_tmr   = (tmr == '1) ? tmr : tmr + 1'b1;
    if (sleep_req && state != hbr_pkg::ST_SLEEP) begin
      // Sleep from anywhere; waking reinitialises the device
      next_state = hbr_pkg::ST_SLEEP;
      next_tmr   = '0;
    end else begin
      unique case (state)
        hbr_pkg::ST_SLEEP: begin
          if (!sleep_req) begin
            next_state = hbr_pkg::ST_CHARGE;
            next_tmr   = '0;
          end
        end
        hbr_pkg::ST_CHARGE: begin
          // Disable held long enough to also force shutdown
          if (!enable) begin
            next_state = hbr_pkg::ST_OFF;
          end else if (tmr >= TW'(CHARGE_CYC - 1)) begin
            next_state = hbr_pkg::ST_RUN;
            next_tmr   = '0;
          end
        end
        hbr_pkg::ST_RUN: begin
          if (!enable) begin
            next_state = hbr_pkg::ST_OFF;
            next_tmr   = '0;
          end else if (clear_req) begin
            next_state = hbr_pkg::ST_CLEAR;
            next_tmr   = '0;
          end
        end
        hbr_pkg::ST_CLEAR: begin
          // Short pulse, outputs keep running
          if (tmr >= TW'(hbr_pkg::DIAG_CYC - 1)) begin
            next_state = hbr_pkg::ST_RUN;
            next_tmr   = '0;
          end
        end
        hbr_pkg::ST_OFF: begin
          // Bootstraps may have drained; charge again before running
          if (enable) begin
            next_state = hbr_pkg::ST_CHARGE;
            next_tmr   = '0;
          end
        end
      endcase
    end
  end

  // Pin patterns, refresh and status next values
  always_comb begin
    active      = (state == hbr_pkg::ST_RUN || state == hbr_pkg::ST_CLEAR);
    next_refr   = (refr != '0) ? refr - 1'b1 : refr;
    start_refr  = 1'b0;
    next_pwm    = 1'b0;
    next_dir    = 1'b0;
    if (active && fast_decay) begin
      // Duty pin held high, modulation goes to direction
      next_pwm  = 1'b1;
      next_dir  = dir_req ? ~pif.pattern : pif.pattern;
    end else if (active) begin
      // Long high-side run gets a short low-gate refresh
      start_refr = (refr == '0) && !pif.pattern
                   && (hs_len >= HW'(HS_MAX_CYC - 1));
      if (start_refr) begin
        next_refr = RW'(hbr_pkg::REFRESH_CYC - 1);
      end
      next_pwm  = pif.pattern || start_refr || (refr != '0);
      next_dir  = dir_req;
    end
    next_hs_len = (active && !next_pwm && hs_len != '1) ? hs_len + 1'b1 : '0;
    // Outside run the device is held disabled, clear pulse included
    next_dis    = !(next_state == hbr_pkg::ST_RUN) ||
                  (next_state == hbr_pkg::ST_CLEAR);
    next_awake  = (next_state != hbr_pkg::ST_SLEEP);
    next_ready  = (next_state == hbr_pkg::ST_RUN);
    next_fault  = flt_decode(shutdown_fault_flag, fault_reason_flag);
  end

  // Registers only; pins start at their safe defaults
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state                  <= hbr_pkg::ST_CHARGE;
      tmr                    <= '0;
      hs_len                 <= '0;
      refr                   <= '0;
      pwm_out                <= 1'b0;
      dir_out                <= 1'b0;
      deadtime_disable_input <= 1'b1;
      awake_out              <= 1'b1;
      ready                  <= 1'b0;
      fault_code             <= hbr_pkg::FLT_NONE;
    end else begin
      state                  <= next_state;
      tmr                    <= next_tmr;
      hs_len                 <= next_hs_len;
      refr                   <= next_refr;
      pwm_out                <= next_pwm;
      dir_out                <= next_dir;
      deadtime_disable_input <= next_dis;
      awake_out              <= next_awake;
      ready                  <= next_ready;
      fault_code             <= next_fault;
    end
  end

  // Checking helpers: length of the current disable-high run
  logic [TW-1:0] dis_len;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dis_len <= '0;
    end else begin
      dis_len <= deadtime_disable_input ? ((dis_len == '1) ? dis_len : dis_len + 1'b1)
                                        : '0;
    end
  end

  property p_clear_width;
    @(posedge mclk) disable iff (!arst_n)
    ($fell(deadtime_disable_input) && $past(state) == hbr_pkg::ST_CLEAR)
      |-> (dis_len >= TW'(hbr_pkg::DIAG_MIN_CYC) && dis_len <= TW'(hbr_pkg::DIAG_MAX_CYC));
  endproperty
  a_clear_width: assert property (p_clear_width) else $error("Clear pulse off window");

  property p_off_width;
    @(posedge mclk) disable iff (!arst_n)
    ($fell(deadtime_disable_input) && $past(state) != hbr_pkg::ST_CLEAR)
      |-> dis_len > TW'(hbr_pkg::OFF_CYC);
  endproperty
  a_off_width: assert property (p_off_width) else $error("Enable after short disable");

  property p_refresh;
    @(posedge mclk) disable iff (!arst_n)
    hs_len <= HW'(HS_MAX_CYC);
  endproperty
  a_refresh: assert property (p_refresh) else $error("High side on too long");

  property p_refresh_len;
    @(posedge mclk) disable iff (!arst_n)
    (start_refr && !fast_decay) |=> pwm_out [*8];
  endproperty
  a_refresh_len: assert property (p_refresh_len) else $error("Refresh pulse cut short");

  property p_duty_clamp;
    @(posedge mclk) disable iff (!arst_n)
    active |-> (pif.high_cyc >= 12'(PERIOD - DLIM) && pif.high_cyc <= 12'(PERIOD));
  endproperty
  a_duty_clamp: assert property (p_duty_clamp) else $error("Duty above limit");

  property p_patterns_late;
    @(posedge mclk) disable iff (!arst_n)
    (pwm_out || dir_out) |-> ($past(state) == hbr_pkg::ST_RUN || $past(state) == hbr_pkg::ST_CLEAR);
  endproperty
  a_patterns_late: assert property (p_patterns_late) else $error("Pattern before start");

  property p_fast;
    @(posedge mclk) disable iff (!arst_n)
    ($past(state) == hbr_pkg::ST_RUN && $past(fast_decay)) |-> pwm_out;
  endproperty
  a_fast: assert property (p_fast) else $error("Duty pin low in fast decay");

  property p_wake;
    @(posedge mclk) disable iff (!arst_n)
    $rose(awake_out) |-> (deadtime_disable_input && state == hbr_pkg::ST_CHARGE && tmr == '0);
  endproperty
  a_wake: assert property (p_wake) else $error("Wake without restart");

  property p_fault;
    @(posedge mclk) disable iff (!arst_n)
    ##1 fault_code == flt_decode($past(shutdown_fault_flag), $past(fault_reason_flag));
  endproperty
  a_fault: assert property (p_fault) else $error("Fault code mismatch");
endmodule

/* hw/hbr_pwm_gen.sv */
// Free-running period counter producing the raw duty pattern
`timescale 1ns/1ps
module hbr_pwm_gen #(
  parameter int PERIOD = hbr_pkg::PERIOD_CYC,
  parameter int W      = 12
) (
  input  wire logic mclk,
  input  wire logic arst_n,
  hbr_pwm_if.gen    pif
);
  logic [W-1:0] cnt;       // Position in the period
  logic [W-1:0] next_cnt;
  logic         next_pat;

  // Refuse a period the counter cannot hold
  if (PERIOD < 2 || PERIOD > (1 << W)) begin : g_chk
    $error("PWM period does not fit the counter");
  end

  // Wrap at the period end; restart from zero while idle
  always_comb begin
    next_cnt = '0;
    next_pat = 1'b0;
    if (pif.run) begin
      next_cnt = (cnt == W'(PERIOD - 1)) ? '0 : cnt + 1'b1;
      next_pat = (next_cnt < pif.high_cyc);
    end
  end

  // Registers only
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt         <= '0;
      pif.pattern <= 1'b0;
    end else begin
      cnt         <= next_cnt;
      pif.pattern <= next_pat;
    end
  end
endmodule
